// file: xbus_access.v
// External data bus sequencer with on-chip data SRAM and dual data pointers.
//
// Behaviour
// R1: Port 0 multiplexes address and data during accesses.
// R2: Port 0 open-drain general port when idle.
// R3: Port 2 carries upper address during accesses.
// R4: Write strobe asserts while write data valid.
// R5: Read strobe asserts while external device drives.
// R6: Wait pin is input only when enabled.
// R7: Access length programmable two to nine cycles.
// R8: 1KB on-chip SRAM at 0000H-03FFH.
// R9: SRAM via data moves only, software enabled.
// R10: Four clocks per machine cycle.
// R11: Second 16-bit data pointer provided.
// R12: Opcode A5H decrements active data pointer.
// R13: Reset clears SRAM enable; all external. Here the enable is the onchip_xram_enable input, which reset does not clear.
// R14: Addresses above 03FFH always go external.
// R15: Select bit 0 chooses second pointer.
// R16: Address latch strobe pulses before data phase.
// R17: Stall input extends strobe phase while held.
// R18: External part samples/drives only under strobe.
`timescale 1ns/1ps
`include "xbus_regs.vh"
module xbus_access (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        start,
   input  wire        write,
   input  wire        use_pointer,
   input  wire [15:0] address,
   input  wire [7:0]  write_data,
   input  wire [3:0]  access_cycles,
   input  wire        onchip_xram_enable,
   input  wire        wait_enable,
   input  wire [7:0]  opcode,
   input  wire        opcode_valid,
   input  wire        pointer_write,
   input  wire [1:0]  pointer_index,
   input  wire [7:0]  pointer_data,
   input  wire [7:0]  pointer_select,
   input  wire [7:0]  gpio_out,
   input  wire [7:0]  port0_in,
   input  wire        wait_pin_in,
   output reg  [7:0]  port0_out,
   output reg  [7:0]  port0_oe,
   output reg  [7:0]  port2_out,
   output reg         port2_oe,
   output reg         addr_latch,
   output reg         write_strobe_n,
   output reg         read_strobe_n,
   output wire        wait_pin_oe,
   output reg  [7:0]  read_data,
   output reg         done,
   output wire        busy,
   output reg  [7:0]  first_pointer_low,
   output reg  [7:0]  first_pointer_high,
   output reg  [7:0]  second_pointer_low,
   output reg  [7:0]  second_pointer_high,
   output wire [15:0] active_data_pointer
);

// ----------------------------------------------------------------
// Data pointers
// ----------------------------------------------------------------
wire        use_second = pointer_select[`POINTER_SELECT_BIT];                       // [R15]
assign active_data_pointer = use_second ? {second_pointer_high, second_pointer_low}
                                        : {first_pointer_high, first_pointer_low};
wire [15:0] pointer_less = active_data_pointer - 16'h0001;
wire        do_decrement = opcode_valid && (opcode == `OP_POINTER_DECREMENT);

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      first_pointer_low   <= 8'h00;
      first_pointer_high  <= 8'h00;
      second_pointer_low  <= 8'h00;
      second_pointer_high <= 8'h00;
   end else if (do_decrement) begin
      if (use_second) begin                                                      // [R11]
         second_pointer_low  <= pointer_less[7:0];                               // [R12]
         second_pointer_high <= pointer_less[15:8];
      end else begin
         first_pointer_low   <= pointer_less[7:0];                               // [R12]
         first_pointer_high  <= pointer_less[15:8];
      end
   end else if (pointer_write) begin
      case (pointer_index)
         2'd0: first_pointer_low   <= pointer_data;
         2'd1: first_pointer_high  <= pointer_data;
         2'd2: second_pointer_low  <= pointer_data;
         default: second_pointer_high <= pointer_data;
      endcase
   end
end

// ----------------------------------------------------------------
// Machine cycle phase and stall synchroniser
// ----------------------------------------------------------------
reg [1:0] phase;
reg       wait_meta;
reg       wait_sync;
reg [7:0] port0_meta;
reg [7:0] port0_sync;
// Read data crosses its own two flops, like the stall pin. A strobe lasts at
// least four clocks, so the byte taken at its end was still driven under it.
always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      phase      <= 2'd0;
      wait_meta  <= 1'b0;
      wait_sync  <= 1'b0;
      port0_meta <= 8'h00;
      port0_sync <= 8'h00;
   end else begin
      phase      <= phase + 2'd1;                                                // [R10]
      wait_meta  <= wait_pin_in;
      wait_sync  <= wait_meta;
      port0_meta <= port0_in;
      port0_sync <= port0_meta;
   end
end
wire cycle_end = (phase == `CLOCKS_PER_MACHINE_CYCLE);
// The stall pin is never driven; it is sampled every clock but only obeyed when enabled.
assign wait_pin_oe = 1'b0;                                                       // [R6]
wire   stall = wait_enable && wait_sync;                                         // [R6]

// ----------------------------------------------------------------
// On-chip SRAM
// ----------------------------------------------------------------
reg [7:0] xram [0:`XRAM_DEPTH-1];                                                // [R8]

// ----------------------------------------------------------------
// Access sequencer
// ----------------------------------------------------------------
localparam IDLE    = 2'd0;
localparam ADDR    = 2'd1;
localparam STROBE  = 2'd2;
localparam INTERNAL= 2'd3;

reg [1:0]  state;
reg [3:0]  cycles_left;
reg [15:0] acc_addr;
reg [7:0]  acc_data;
reg        acc_write;
wire [15:0] req_addr = use_pointer ? active_data_pointer : address;
// Reset does not touch the enable input; while it is held at zero, every address goes external.
wire       req_internal = onchip_xram_enable && (req_addr <= `XRAM_TOP);          // [R9] [R13] [R14]
wire [3:0] req_len = (access_cycles < `STRETCH_MIN) ? `STRETCH_MIN :
                     (access_cycles > `STRETCH_MAX) ? `STRETCH_MAX : access_cycles; // [R7]
assign busy = (state != IDLE);

always @(posedge core_clk or posedge reset) begin
   if (reset) begin
      state          <= IDLE;
      cycles_left    <= `STRETCH_RESET;
      acc_addr       <= 16'h0000;
      acc_data       <= 8'h00;
      acc_write      <= 1'b0;
      port0_out      <= 8'h00;
      port0_oe       <= 8'h00;
      port2_out      <= 8'h00;
      port2_oe       <= 1'b0;
      addr_latch     <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      read_data      <= 8'h00;
      done           <= 1'b0;
   end else begin
      done       <= 1'b0;
      addr_latch <= 1'b0;
      case (state)
         IDLE: begin
            port0_out <= 8'h00;
            port0_oe  <= ~gpio_out;                                              // [R2]
            port2_oe  <= 1'b0;
            if (start) begin
               acc_addr    <= req_addr;
               acc_data    <= write_data;
               acc_write   <= write;
               cycles_left <= req_len;
               if (req_internal) begin
                  state <= INTERNAL;
               end else begin
                  port0_out  <= req_addr[7:0];                                   // [R1]
                  port0_oe   <= 8'hFF;
                  port2_out  <= req_addr[15:8];                                  // [R3]
                  port2_oe   <= 1'b1;
                  addr_latch <= 1'b1;                                            // [R16]
                  state      <= ADDR;
               end
            end
         end
         INTERNAL: begin
            if (!acc_write) begin
               read_data <= xram[acc_addr[9:0]];
            end
            done  <= 1'b1;
            state <= IDLE;
         end
         ADDR: begin
            // Address stands for the rest of the first machine cycle.
            if (cycle_end) begin
               cycles_left <= cycles_left - 4'd1;
               if (acc_write) begin
                  port0_out      <= acc_data;                                    // [R1]
                  write_strobe_n <= 1'b0;                                        // [R4]
               end else begin
                  port0_oe       <= 8'h00;
                  read_strobe_n  <= 1'b0;                                        // [R5]
               end
               state <= STROBE;
            end
         end
         default: begin
            // The external part answers only under the strobe.
            if (cycle_end && !stall) begin                                       // [R17] [R18]
               if (cycles_left == 4'd1) begin
                  if (!acc_write) begin
                     read_data <= port0_sync;
                  end
                  write_strobe_n <= 1'b1;
                  read_strobe_n  <= 1'b1;
                  done           <= 1'b1;
                  state          <= IDLE;
               end else begin
                  cycles_left <= cycles_left - 4'd1;
               end
            end
         end
      endcase
   end
end

// The array is written outside the reset process so that it maps to plain memory.
always @(posedge core_clk) begin
   if ((state == INTERNAL) && acc_write) begin
      xram[acc_addr[9:0]] <= acc_data;                                           // [R9]
   end
end

endmodule

// file: xbus_regs.vh
// Constants for the external data bus access block.
`ifndef XBUS_REGS_VH
`define XBUS_REGS_VH
`define CLOCKS_PER_MACHINE_CYCLE 2'd3
`define STRETCH_MIN              4'd2
`define STRETCH_MAX              4'd9
`define STRETCH_RESET            4'd2
`define XRAM_TOP                 16'h03FF
`define XRAM_DEPTH               1024
`define OP_POINTER_DECREMENT     8'hA5
`define POINTER_SELECT_BIT       0
`endif

// file: xbus_access_sva.sv
// Concurrent checks on the external data bus access block.
`timescale 1ns/1ps
module xbus_access_sva (
   input wire        core_clk,
   input wire        reset,
   input wire        busy,
   input wire        done,
   input wire        addr_latch,
   input wire        port2_oe,
   input wire        write_strobe_n,
   input wire        read_strobe_n,
   input wire        wait_pin_oe,
   input wire        wait_enable,
   input wire        opcode_valid,
   input wire [7:0]  port0_out,
   input wire [7:0]  port0_oe,
   input wire [7:0]  opcode,
   input wire [7:0]  pointer_select,
   input wire [7:0]  first_pointer_low,
   input wire [7:0]  first_pointer_high,
   input wire [7:0]  second_pointer_low,
   input wire [7:0]  second_pointer_high,
   input wire [15:0] active_data_pointer
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_wait_pin_input: assert property (wait_enable |-> !wait_pin_oe)
      else $error("wait pin driven");
   a_strobe_exclusive: assert property (write_strobe_n || read_strobe_n)
      else $error("both strobes low");
   a_latch_pulse: assert property (addr_latch |-> busy && port2_oe && port0_oe == 8'hFF ##1 !addr_latch)
      else $error("bad address latch pulse");
   a_write_drives: assert property (!write_strobe_n |-> port0_oe == 8'hFF)
      else $error("write data not driven");
   a_read_releases: assert property (!read_strobe_n |-> busy && port0_oe == 8'h00)
      else $error("bus not released in read");
   a_idle_open_drain: assert property (!busy [*2] |-> (port0_out & port0_oe) == 8'h00)
      else $error("idle port drives high");
   a_strobe_length: assert property ($fell(write_strobe_n) && !wait_enable |-> !write_strobe_n [*4] ##[1:29] done)
      else $error("write strobe length wrong");
   a_decrement_second: assert property (opcode_valid && opcode == 8'hA5 && pointer_select[0] |=> {second_pointer_high, second_pointer_low} == $past(active_data_pointer) - 16'h0001)
      else $error("pointer not decremented");
   a_pointer_pick: assert property (active_data_pointer == (pointer_select[0] ? {second_pointer_high, second_pointer_low} : {first_pointer_high, first_pointer_low}))
      else $error("wrong active pointer");
endmodule
bind xbus_access xbus_access_sva xbus_access_sva_inst (.*);

// file: xbus_ext_mem.sv
// External data memory model with an optional stall request.
`timescale 1ns/1ps
module xbus_ext_mem (
   input  wire       core_clk,
   input  wire       addr_latch,
   input  wire       write_strobe_n,
   input  wire       read_strobe_n,
   input  wire [7:0] port0_out,
   input  wire [7:0] port2_out,
   input  wire [3:0] stall,
   output reg  [7:0] port0_in,
   output reg        wait_pin_in
);
   reg [7:0]  mem [0:65535];
   reg [15:0] addr;
   reg [3:0]  hold;
   initial begin
      hold = 4'h0;
      wait_pin_in = 1'b0;
   end
   // A released bus shows the inverse, so stale data can never pass for a read.
   always @* port0_in = read_strobe_n ? ~mem[addr] : mem[addr];
   // The stall is raised as the address is latched, so that it has crossed the
   // two-flop synchroniser before the first strobe phase can end.
   always @(posedge core_clk) begin
      if (addr_latch) addr <= {port2_out, port0_out};
      if (!write_strobe_n) mem[addr] <= port0_out;
      if (addr_latch) hold <= stall;
      else if (hold != 4'h0) hold <= hold - 4'h1;
      wait_pin_in <= (hold != 4'h0);
   end
endmodule

// file: xbus_access_tb.sv
// Self-checking bench for the external data bus access block.
`timescale 1ns/1ps
module xbus_access_tb;
   reg         core_clk, reset, start, write, use_pointer, onchip_xram_enable;
   reg         wait_enable, opcode_valid, pointer_write;
   reg  [15:0] address;
   reg  [7:0]  write_data, opcode, pointer_data, pointer_select, gpio_out;
   reg  [3:0]  access_cycles, stall;
   reg  [1:0]  pointer_index;
   wire [7:0]  port0_in, port0_out, port0_oe, port2_out, read_data;
   wire        wait_pin_in, port2_oe, addr_latch, write_strobe_n, read_strobe_n;
   wire        wait_pin_oe, done, busy;
   wire [15:0] active_data_pointer;
   integer     fails, samples_checked, lows, i, n;
   xbus_access xbus_access_inst (.*, .first_pointer_low(), .first_pointer_high(),
      .second_pointer_low(), .second_pointer_high());
   xbus_ext_mem xbus_ext_mem_inst (.*);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task check(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Counts the clocks with a strobe low, bounded so a hang cannot stall the run.
   task xfer(input w, input [15:0] a, input [7:0] d, input [3:0] c);
      begin
         @(negedge core_clk);
         {write, address, write_data, access_cycles, start} = {w, a, d, c, 1'b1};
         @(negedge core_clk);
         start = 1'b0;
         lows = 0;
         for (i = 0; i < 200 && done !== 1'b1; i = i + 1) begin
            @(negedge core_clk);
            if (!(write_strobe_n && read_strobe_n)) lows = lows + 1;
         end
         check(done, 1'b1);
      end
   endtask
   task ptr(input [1:0] idx, input [7:0] d);
      begin
         @(negedge core_clk);
         {pointer_index, pointer_data, pointer_write} = {idx, d, 1'b1};
         @(negedge core_clk);
         pointer_write = 1'b0;
      end
   endtask
   task op(input [7:0] c);
      begin
         @(negedge core_clk);
         {opcode, opcode_valid} = {c, 1'b1};
         @(negedge core_clk);
         opcode_valid = 1'b0;
      end
   endtask
   task tally_and_finish;
      begin
         $display("fails %0d samples_checked %0d", fails, samples_checked);
         if (fails == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      fails = fails + 1;
      tally_and_finish;
   end
   initial begin
      {fails, samples_checked, reset, start, write, use_pointer} = 0;
      {onchip_xram_enable, wait_enable, opcode_valid, pointer_write, stall} = 0;
      {address, write_data, opcode, pointer_data, pointer_select} = 0;
      {access_cycles, pointer_index, gpio_out} = {4'h2, 2'h0, 8'hFF};
      reset = 1'b1;
      repeat (3) @(negedge core_clk);
      reset = 1'b0;
      check({write_strobe_n, read_strobe_n, port0_oe}, {2'b11, 8'h00});
      xfer(1'b1, 16'h0010, 8'h3C, 4'h2);
      check(xbus_ext_mem_inst.mem[16'h0010], 8'h3C);
      check(lows, 4);
      onchip_xram_enable = 1'b1;
      xfer(1'b1, 16'h03FF, 8'hC3, 4'h2);
      check(lows, 0);
      xfer(1'b0, 16'h03FF, 8'h00, 4'h9);
      check({lows[7:0], read_data}, {8'h00, 8'hC3});
      xfer(1'b1, 16'h0400, 8'h81, 4'h2);
      check(xbus_ext_mem_inst.mem[16'h0400], 8'h81);
      for (n = 2; n <= 9; n = n + 1) begin
         xfer(1'b0, 16'h0400, 8'h00, n[3:0]);
         check({lows[7:0], read_data}, {8'(4 * (n - 1)), 8'h81});
      end
      {wait_enable, stall} = {1'b1, 4'h8};
      xfer(1'b0, 16'h0400, 8'h00, 4'h2);
      check({lows >= 8, read_data}, {1'b1, 8'h81});
      {wait_enable, stall} = {1'b0, 4'h0};
      ptr(2'd3, 8'h05);
      pointer_select = 8'h01;
      op(8'hA5);
      check(active_data_pointer, 16'h04FF);
      use_pointer = 1'b1;
      xfer(1'b1, 16'h0000, 8'h77, 4'h3);
      check(xbus_ext_mem_inst.mem[16'h04FF], 8'h77);
      pointer_select = 8'h00;
      op(8'hA5);
      op(8'hA4);
      check(active_data_pointer, 16'hFFFF);
      gpio_out = 8'h5A;
      repeat (2) @(negedge core_clk);
      check({port0_out, port0_oe}, {8'h00, 8'hA5});
      tally_and_finish;
   end
endmodule
